// ### hw/vms_mode_seq.sv
`include "vms_consts.svh"
module vms_mode_seq (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Reset sources from chip reset logic, active high
  input wire logic [`VMS_NUM_RST_SRC-1:0] rst_src,
  // CPU side
  input wire logic stop_on_wait_select,
  input wire logic cpu_wait_exec,
  input wire logic cpu_stop_exec,
  input wire logic cpu_running,
  // Link side, received line from transceiver (active level high)
  input wire logic link_rx,
  // Status outputs
  output vms_pkg::vms_mode_e mode,
  output logic ctrl_clk_en,
  output logic link_drive_en,
  output logic rx_valid_en,
  output logic module_reset,
  output logic nmi_req,
  output logic [3:0] interrupt_state_vector
);
  import vms_pkg::*;

  // ----------------------------------------
  // Activity sensing
  // ----------------------------------------
  logic rx_gated; // Line is ignored while in reset mode
  logic act_pulse; // One-cycle passive-to-active pulse
  logic any_rst; // Some reset source is asserted
  // Reset sources are OR-ed as levels; no source has priority over another
  assign any_rst = |rst_src;
  // Gating the line in reset also keeps the edge detector history low, so a line
  // still high in the first run cycle shows up there as a rise
  assign rx_gated = link_rx & (mode != VMS_RESET);

  vms_edge_det u_edge (
    .clk(clk),
    .arst_n(arst_n),
    .line(rx_gated),
    .rise(act_pulse)
  );

  // ----------------------------------------
  // Mode state machine
  // ----------------------------------------
  vms_mode_e mode_q, mode_d; // Current mode
  logic nmi_q, nmi_d; // Wakeup interrupt, held until a reset source clears it
  logic [3:0] vec_q, vec_d; // Interrupt state vector
  logic stab_q, stab_d; // Clocks stable after stop exit
  logic rst_q, rst_d; // Module reset output
  logic clk_en_q, clk_en_d; // Internal clock enable
  logic drv_q, drv_d; // May drive the link
  logic rxv_q, rxv_d; // Receive results trustworthy

  // Next-state logic; the enum can only hold the four legal modes
  always_comb begin
    mode_d = mode_q;
    nmi_d = nmi_q;
    vec_d = vec_q;
    stab_d = stab_q;
    if (any_rst) begin
      mode_d = VMS_RESET;
      nmi_d = 1'b0;
      vec_d = `VMS_VEC_NONE;
      stab_d = 1'b1;
    end else begin
      case (mode_q)
        VMS_RESET: begin
          mode_d = VMS_RUN;
        end
        VMS_RUN: begin
          // Software must have ended any transmission before this point
          if (stop_on_wait_select && (cpu_wait_exec || cpu_stop_exec)) begin
            mode_d = VMS_STOP;
          end else if (!stop_on_wait_select && cpu_wait_exec) begin
            mode_d = VMS_WAIT;
          end
          // Stop on a clear select is not a listed transition
          if (!stab_q && cpu_running) begin
            stab_d = 1'b1;
          end
        end
        VMS_WAIT: begin
          if (act_pulse) begin
            mode_d = VMS_RUN;
          end
        end
        VMS_STOP: begin
          if (act_pulse) begin
            mode_d = VMS_RUN;
            nmi_d = 1'b1;
            vec_d = `VMS_VEC_WAKEUP;
            stab_d = 1'b0;
          end
        end
        default: begin
          mode_d = VMS_RESET;
        end
      endcase
    end
    // Output levels derived from the next mode; vector and flags untouched
    rst_d = (mode_d == VMS_RESET);
    clk_en_d = (mode_d != VMS_STOP);
    drv_d = (mode_d == VMS_RUN);
    rxv_d = (mode_d == VMS_RUN) && stab_d;
  end

  // Register stage; module reset output defaults asserted
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= VMS_RESET;
      nmi_q <= 1'b0;
      vec_q <= `VMS_VEC_NONE;
      stab_q <= 1'b1;
      rst_q <= 1'b1;
      clk_en_q <= 1'b1;
      drv_q <= 1'b0;
      rxv_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      nmi_q <= nmi_d;
      vec_q <= vec_d;
      stab_q <= stab_d;
      rst_q <= rst_d;
      clk_en_q <= clk_en_d;
      drv_q <= drv_d;
      rxv_q <= rxv_d;
    end
  end

  // ----------------------------------------
  // Outputs, each straight from its register
  // ----------------------------------------
  // Registering outputs from the next-mode decode keeps them in step with mode
  // and gives the CPU side glitch-free levels
  assign mode = mode_q;
  assign nmi_req = nmi_q;
  assign interrupt_state_vector = vec_q;
  assign module_reset = rst_q;
  assign ctrl_clk_en = clk_en_q;
  assign link_drive_en = drv_q;
  assign rx_valid_en = rxv_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  reset_entry_a: assert property (any_rst |=> mode == VMS_RESET)
    else $error("reset source did not force reset mode");
  reset_outputs_a: assert property (mode == VMS_RESET |->
    module_reset && !link_drive_en && vec_q == `VMS_VEC_NONE)
    else $error("reset mode outputs wrong");
  reset_exit_a: assert property (mode == VMS_RESET && !any_rst |=> mode == VMS_RUN)
    else $error("reset release did not enter run");
  reset_hold_a: assert property (mode == VMS_RESET && any_rst |=> mode == VMS_RESET)
    else $error("left reset with source asserted");
  wait_wake_a: assert property (mode == VMS_WAIT && act_pulse && !any_rst |=> mode == VMS_RUN)
    else $error("wait mode ignored activity");
  stop_wake_a: assert property (mode == VMS_STOP && act_pulse && !any_rst |=>
    mode == VMS_RUN && nmi_req && interrupt_state_vector == `VMS_VEC_WAKEUP)
    else $error("stop wakeup missing interrupt");
  wait_entry_a: assert property (mode == VMS_RUN && !any_rst &&
    !stop_on_wait_select && cpu_wait_exec |=> mode == VMS_WAIT ##0 !link_drive_en)
    else $error("wait entry wrong");
  stop_entry_a: assert property (mode == VMS_RUN && !any_rst &&
    stop_on_wait_select && (cpu_wait_exec || cpu_stop_exec) |=>
    mode == VMS_STOP && !ctrl_clk_en)
    else $error("stop entry wrong");
  ignore_req_a: assert property (mode == VMS_RUN && !any_rst &&
    !stop_on_wait_select && !cpu_wait_exec |=> mode == VMS_RUN)
    else $error("unlisted request changed mode");
  keep_vec_a: assert property (mode == VMS_WAIT && !any_rst |=> $stable(vec_q))
    else $error("wait wakeup altered vector");
  rx_stab_a: assert property (!stab_q |-> !rx_valid_en)
    else $error("receive valid before clocks stable");
  // Internal clocks halt only in stop mode
  stop_clk_a: assert property (mode == VMS_STOP |-> !ctrl_clk_en)
    else $error("clock enabled in stop mode");
  // Wait mode keeps its clocks running but may not drive the link
  wait_clk_a: assert property (mode == VMS_WAIT |-> ctrl_clk_en && !link_drive_en)
    else $error("wait mode clock or drive wrong");
  // The link may be driven in run mode only
  drive_run_a: assert property (link_drive_en |-> mode == VMS_RUN)
    else $error("link driven outside run mode");
  // The system clock keeps running while held in reset
  reset_clk_a: assert property (mode == VMS_RESET |-> ctrl_clk_en)
    else $error("clock stopped in reset mode");
  // Nothing received is trusted in reset, and the line is cut off
  reset_rx_a: assert property (mode == VMS_RESET |-> !rx_valid_en && !rx_gated)
    else $error("input not ignored in reset mode");
  // The wakeup interrupt stays raised until a reset clears it
  nmi_hold_a: assert property (nmi_req && !any_rst |=> nmi_req)
    else $error("wakeup interrupt dropped");
  // Without activity the low-power modes are kept
  stop_hold_a: assert property (mode == VMS_STOP && !act_pulse && !any_rst |=>
    mode == VMS_STOP)
    else $error("stop mode left without activity");
  wait_hold_a: assert property (mode == VMS_WAIT && !act_pulse && !any_rst |=>
    mode == VMS_WAIT)
    else $error("wait mode left without activity");
  // A running CPU in run mode marks the clocks stable again
  stab_set_a: assert property (mode == VMS_RUN && !stab_q && cpu_running &&
    !any_rst && !stop_on_wait_select && !cpu_wait_exec |=> rx_valid_en)
    else $error("receive valid not restored");
  // In stop mode the vector either holds or changes only to the wakeup code
  stop_vec_a: assert property (mode == VMS_STOP && !any_rst |=>
    interrupt_state_vector == `VMS_VEC_WAKEUP || $stable(interrupt_state_vector))
    else $error("stop wakeup altered vector");

  // ----------------------------------------
  // Coverage of the main scenarios
  // ----------------------------------------

  wait_cycle_c: cover property (mode == VMS_RUN ##1 mode == VMS_WAIT ##[1:20] mode == VMS_RUN);
  stop_cycle_c: cover property (mode == VMS_STOP ##1 nmi_req);
  reset_run_c: cover property (mode == VMS_RESET ##1 mode == VMS_RUN);
  // Receive trust restored after a stop wakeup
  stab_back_c: cover property (!stab_q ##1 rx_valid_en);
  // Reset taken from a low-power mode
  lp_reset_c: cover property ((mode == VMS_WAIT || mode == VMS_STOP) ##1 mode == VMS_RESET);
endmodule // vms_mode_seq

// ### pkg/vms_consts.svh
// What this block does
// - Any reset source forces reset mode
// - Reset mode: registers cleared, clock runs
// - Reset mode: outputs at reset levels, inputs ignored
// - Leave reset only when all sources released
// - Wait mode returns to run on activity
// - Stop mode returns to run on activity
// - Wait entry: select clear plus wait
// - Stop entry: select set plus wait/stop
// - Stop exit raises top-priority non-maskable wakeup
// - Wait wakeup preserves controller registers; stop wakeup sets the wakeup interrupt and vector
`ifndef VMS_CONSTS_SVH
`define VMS_CONSTS_SVH
// ----------------------------------------
// Reset sources and vector codes
// ----------------------------------------
`define VMS_NUM_RST_SRC 4
`define VMS_VEC_NONE 4'h0
`define VMS_VEC_WAKEUP 4'h8
`define VMS_MODE_RST_VAL 2'h0
`endif

// ### pkg/vms_pkg.sv
package vms_pkg;
  // Operating modes with binary codes written out
  typedef enum logic [1:0] {
    VMS_RESET = 2'b00,
    VMS_RUN = 2'b01,
    VMS_WAIT = 2'b10,
    VMS_STOP = 2'b11
  } vms_mode_e;
endpackage

// ### hw/vms_edge_det.sv
`include "vms_consts.svh"
// Rising-edge detector on the reset-gated link line; passive-to-active marks activity
module vms_edge_det (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Line and pulse
  input wire logic line,
  output logic rise
);
  logic prev_q; // Last sampled line level
  logic prev_d;
  always_comb begin
    prev_d = line;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
    end
  end
  assign rise = line & ~prev_q;
endmodule // vms_edge_det

// ### bench/vms_net_model.sv
module vms_net_model (
  // Bench request for bus activity
  act,
  // Received line towards the block
  link_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  input wire logic act;
  output logic link_rx;
  // ----------------------------------------
  // Network line
  // ----------------------------------------
  // Bus rests passive low between frames, so a wakeup is a clean rising edge
  assign link_rx = act;
endmodule // vms_net_model

// ### bench/test_vpw_link_mode_sequencer.sv
`include "vms_consts.svh"
module test_vpw_link_mode_sequencer;
  import vms_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Stimulus, model state and counters
  // ----------------------------------------
  logic clk, arst_n, sel, w, s, run, act, link_rx, clk_en, drv, rxv, mrst, nmi;
  logic [3:0] rst_src, vec;
  vms_mode_e mode, e_mode;
  logic e_nmi, prev_rx;
  int fail_count = 0, n_tests = 0, cyc = 0;
  vms_net_model i_net (.act(act), .link_rx(link_rx));
  vms_mode_seq i_dut (.clk(clk), .arst_n(arst_n), .rst_src(rst_src),
    .stop_on_wait_select(sel), .cpu_wait_exec(w), .cpu_stop_exec(s), .cpu_running(run),
    .link_rx(link_rx), .mode(mode), .ctrl_clk_en(clk_en), .link_drive_en(drv),
    .rx_valid_en(rxv), .module_reset(mrst), .nmi_req(nmi), .interrupt_state_vector(vec));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Hang guard: far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [9:0] e, input logic [9:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  // Status word implied by a mode and the wakeup flag
  function automatic logic [9:0] exp_out(input vms_mode_e m, input logic n);
    return {m, m != VMS_STOP, m == VMS_RUN, m == VMS_RESET, n,
      n ? `VMS_VEC_WAKEUP : `VMS_VEC_NONE};
  endfunction
  // Apply one cycle of inputs at the falling edge, predict, then check
  task automatic step(input logic [3:0] sr, input logic sl, wi, si, ai, ri);
    vms_mode_e nm;
    rst_src = sr;
    sel = sl;
    w = wi;
    s = si;
    act = ai;
    run = ri;
    nm = e_mode;
    if (|sr) nm = VMS_RESET;
    else case (e_mode)
      VMS_RESET: nm = VMS_RUN;
      VMS_RUN: if (wi) nm = sl ? VMS_STOP : VMS_WAIT; else if (si && sl) nm = VMS_STOP;
      default: if (ai && !prev_rx) nm = VMS_RUN;
    endcase
    e_nmi = (|sr) ? 1'b0 : (e_nmi | (e_mode == VMS_STOP && nm == VMS_RUN));
    e_mode = nm;
    prev_rx = ai;
    @(negedge clk);
    chk(exp_out(e_mode, e_nmi), {mode, clk_en, drv, mrst, nmi, vec});
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h2cfea9d2));
    {arst_n, rst_src, sel, w, s, run, act, e_nmi, prev_rx} = '0;
    e_mode = VMS_RESET;
    repeat (4) @(negedge clk);
    chk(exp_out(VMS_RESET, 1'b0), {mode, clk_en, drv, mrst, nmi, vec});
    arst_n = 1'b1;
    step(4'h4, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    step(4'h4, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    step(4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    step(4'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    step(4'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    step(4'h0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    step(4'h0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    step(4'h0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    chk(10'h000, {9'h000, rxv});
    step(4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    chk(10'h001, {9'h000, rxv});
    step(4'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    step(4'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    for (int i = 0; i < 4; i++) begin
      step(4'h1 << i, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      step(4'h0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    end
    // Random mix; reset sources kept rare so low-power modes get visited
    repeat (400) step((($urandom % 16) == 0) ? 4'($urandom) : 4'h0, 1'($urandom),
      1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom));
    finish_test();
  end
endmodule // test_vpw_link_mode_sequencer
